//--- core/rsl_link.sv
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ns
module rsl_link #(
	parameter int MS_CYCLES = rsl_pkg::MS_CYC,
	parameter int DS_CYCLES = rsl_pkg::DS_CYC
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial line
	input wire logic rxd,
	output logic txd,
	// interrupt
	output logic irq
);
	typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PAR, R_STOP}
		rsl_rst_type;
	rsl_tx_if txi();

	logic [2:0] rate_r, rate_nxt, fmt_r, fmt_nxt;
	logic [7:0] dly_r, dly_nxt, txh_r, txh_nxt, rxd_r, rxd_nxt;
	logic [9:0] tmo_r, tmo_nxt;
	logic [rsl_pkg::NEV-1:0] st_r, st_nxt, msk_r, msk_nxt;
	logic pend_r, pend_nxt, busy_q, start;
	logic [31:0] rdata_r, rdata_nxt;
	logic wr, rd, hit;
	logic [1:0] rx_sync;
	logic [rsl_pkg::DIV_W-1:0] div;
	logic par_en, par_odd;
	// receiver state
	rsl_rst_type rs_r, rs_nxt;
	logic [rsl_pkg::DIV_W-1:0] rc_r, rc_nxt;
	logic [2:0] rb_r, rb_nxt;
	logic [7:0] rsh_r, rsh_nxt;
	logic rpar_r, rpar_nxt, rerr_r, rerr_nxt;
	logic rx_ok, rx_bad;
	// timers
	logic [31:0] mspre_r, mspre_nxt, dspre_r, dspre_nxt;
	logic [7:0] gap_r, gap_nxt;
	logic [9:0] idle_r, idle_nxt;
	logic gap_ok, tmo_hit;

	// format decode: codes 0..2 one stop, 3..7 two stops
	assign div = rsl_pkg::rate_div(rate_r);
	assign par_en = (fmt_r != 3'h0) && (fmt_r != 3'h3);
	assign par_odd = (fmt_r == 3'h2) || (fmt_r == 3'h5);
	assign txi.div = div;
	assign txi.par_en = par_en;
	assign txi.par_odd = par_odd;
	assign txi.two_stop = (fmt_r >= 3'h3);
	assign txi.data = txh_r;
	assign txi.start = start;

	rsl_tx u_tx (
		.pclk(pclk),
		.presetn(presetn),
		.txp(txi.ctl),
		.txd(txd)
	);

	// apb decode, zero wait states
	assign wr = psel && penable && pwrite;
	assign rd = psel && !pwrite;
	always_comb begin
		case (paddr)
			rsl_pkg::OFS_CTRL, rsl_pkg::OFS_DELAY, rsl_pkg::OFS_TMO,
			rsl_pkg::OFS_STAT, rsl_pkg::OFS_MASK, rsl_pkg::OFS_TXD,
			rsl_pkg::OFS_RXD: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign prdata = rdata_r;
	assign irq = |(st_r & msk_r);

	// reply released only once the gap has run out
	assign gap_ok = (gap_r >= dly_r);
	assign start = pend_r && !txi.busy && gap_ok;

	// register file next state; hardware set beats software clear
	always_comb begin
		rate_nxt = rate_r;
		fmt_nxt = fmt_r;
		dly_nxt = dly_r;
		tmo_nxt = tmo_r;
		msk_nxt = msk_r;
		txh_nxt = txh_r;
		pend_nxt = pend_r && !start;
		st_nxt = st_r;
		rdata_nxt = rdata_r;
		if (wr) begin
			case (paddr)
				rsl_pkg::OFS_CTRL: begin
					rate_nxt = pwdata[rsl_pkg::CTRL_RATE_LSB +: 3];
					fmt_nxt = pwdata[rsl_pkg::CTRL_FMT_LSB +: 3];
				end
				rsl_pkg::OFS_DELAY: if (pwdata[7:0] <= 8'(rsl_pkg::REPLY_MAX_MS))
					dly_nxt = pwdata[7:0];
				rsl_pkg::OFS_TMO:
					if (pwdata[9:0] <= 10'(rsl_pkg::TIMEOUT_MAX_DS))
						tmo_nxt = pwdata[9:0];
				rsl_pkg::OFS_STAT: st_nxt = st_r & ~pwdata[rsl_pkg::NEV-1:0];
				rsl_pkg::OFS_MASK: msk_nxt = pwdata[rsl_pkg::NEV-1:0];
				rsl_pkg::OFS_TXD: if (!pend_r) begin
					txh_nxt = pwdata[7:0];
					pend_nxt = 1'b1;
				end
				default: ;
			endcase
		end
		if (rx_ok)
			st_nxt[rsl_pkg::ST_RX] = 1'b1;
		if (rx_bad)
			st_nxt[rsl_pkg::ST_RXERR] = 1'b1;
		if (busy_q && !txi.busy)
			st_nxt[rsl_pkg::ST_TXDONE] = 1'b1;
		if (tmo_hit)
			st_nxt[rsl_pkg::ST_TMO] = 1'b1;
		if (rd && !penable) begin
			case (paddr)
				rsl_pkg::OFS_CTRL: rdata_nxt = 32'({fmt_r, 1'b0, rate_r});
				rsl_pkg::OFS_DELAY: rdata_nxt = 32'(dly_r);
				rsl_pkg::OFS_TMO: rdata_nxt = 32'(tmo_r);
				rsl_pkg::OFS_STAT: rdata_nxt = 32'({pend_r, st_r});
				rsl_pkg::OFS_MASK: rdata_nxt = 32'(msk_r);
				rsl_pkg::OFS_TXD: rdata_nxt = 32'(txh_r);
				rsl_pkg::OFS_RXD: rdata_nxt = 32'(rxd_r);
				default: rdata_nxt = 32'h00000000;
			endcase
		end
	end

	// receiver: centre sampling, parity and first stop checked
	always_comb begin
		rs_nxt = rs_r;
		rc_nxt = rc_r + 1'b1;
		rb_nxt = rb_r;
		rsh_nxt = rsh_r;
		rpar_nxt = rpar_r;
		rerr_nxt = rerr_r;
		rxd_nxt = rxd_r;
		rx_ok = 1'b0;
		rx_bad = 1'b0;
		case (rs_r)
			R_IDLE: begin
				rc_nxt = '0;
				if (!rx_sync[1]) begin
					rs_nxt = R_START;
					rpar_nxt = par_odd;
					rerr_nxt = 1'b0;
				end
			end
			R_START: if (rc_r == (div >> 1)) begin
				rc_nxt = '0;
				rb_nxt = '0;
				rs_nxt = rx_sync[1] ? R_IDLE : R_DATA;
			end
			R_DATA: if (rc_r == div - 1'b1) begin
				rc_nxt = '0;
				rsh_nxt = {rx_sync[1], rsh_r[7:1]};
				rpar_nxt = rpar_r ^ rx_sync[1];
				rb_nxt = rb_r + 1'b1;
				if (rb_r == 3'h7)
					rs_nxt = par_en ? R_PAR : R_STOP;
			end
			R_PAR: if (rc_r == div - 1'b1) begin
				rc_nxt = '0;
				rerr_nxt = rpar_r ^ rx_sync[1];
				rs_nxt = R_STOP;
			end
			R_STOP: if (rc_r == div - 1'b1) begin
				rs_nxt = R_IDLE;
				if (rx_sync[1] && !rerr_r) begin
					rx_ok = 1'b1;
					rxd_nxt = rsh_r;
				end else
					rx_bad = 1'b1;
			end
			default: rs_nxt = R_IDLE;
		endcase
	end

	// reply gap in ms and link idle time in 0.1 s
	always_comb begin
		mspre_nxt = mspre_r + 1;
		gap_nxt = gap_r;
		dspre_nxt = dspre_r + 1;
		idle_nxt = idle_r;
		tmo_hit = 1'b0;
		if (rs_r != R_IDLE || rx_ok || rx_bad) begin
			mspre_nxt = 0;
			gap_nxt = '0;
		end else if (mspre_r == MS_CYCLES - 1) begin
			mspre_nxt = 0;
			if (gap_r != 8'hFF)
				gap_nxt = gap_r + 1'b1;
		end
		if (rx_ok || tmo_r == 10'h000) begin
			dspre_nxt = 0;
			idle_nxt = '0;
		end else if (dspre_r == DS_CYCLES - 1) begin
			dspre_nxt = 0;
			idle_nxt = idle_r + 1'b1;
			if (idle_r + 1'b1 >= tmo_r) begin
				tmo_hit = 1'b1;
				idle_nxt = '0;
			end
		end
	end

	// all state registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rate_r <= rsl_pkg::RATE_RST;
			fmt_r <= rsl_pkg::FMT_RST;
			dly_r <= rsl_pkg::DELAY_RST;
			tmo_r <= rsl_pkg::TMO_RST;
			msk_r <= '0;
			st_r <= '0;
			txh_r <= '0;
			pend_r <= 1'b0;
			busy_q <= 1'b0;
			rdata_r <= '0;
			rx_sync <= 2'h3;
			rs_r <= R_IDLE;
			rc_r <= '0;
			rb_r <= '0;
			rsh_r <= '0;
			rpar_r <= 1'b0;
			rerr_r <= 1'b0;
			rxd_r <= '0;
			mspre_r <= 0;
			gap_r <= 8'hFF;
			dspre_r <= 0;
			idle_r <= '0;
		end else begin
			rate_r <= rate_nxt;
			fmt_r <= fmt_nxt;
			dly_r <= dly_nxt;
			tmo_r <= tmo_nxt;
			msk_r <= msk_nxt;
			st_r <= st_nxt;
			txh_r <= txh_nxt;
			pend_r <= pend_nxt;
			busy_q <= txi.busy;
			rdata_r <= rdata_nxt;
			rx_sync <= {rx_sync[0], rxd};
			rs_r <= rs_nxt;
			rc_r <= rc_nxt;
			rb_r <= rb_nxt;
			rsh_r <= rsh_nxt;
			rpar_r <= rpar_nxt;
			rerr_r <= rerr_nxt;
			rxd_r <= rxd_nxt;
			mspre_r <= mspre_nxt;
			gap_r <= gap_nxt;
			dspre_r <= dspre_nxt;
			idle_r <= idle_nxt;
		end
	end
endmodule // rsl_link

//--- core/rsl_tx.sv
`timescale 1ns/1ns
module rsl_tx (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control side
	rsl_tx_if.tx txp,
	// serial line
	output logic txd
);
	typedef enum logic [2:0] {T_IDLE, T_START, T_DATA, T_PAR, T_STOP}
		rsl_tst_type;
	rsl_tst_type st_r, st_nxt;
	logic [rsl_pkg::DIV_W-1:0] cnt_r, cnt_nxt;
	logic [2:0] bit_r, bit_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic par_r, par_nxt;
	logic stop2_r, stop2_nxt;
	logic txd_r, txd_nxt;
	logic bit_end;

	assign bit_end = (cnt_r == txp.div - 1'b1);
	assign txp.busy = (st_r != T_IDLE);
	assign txd = txd_r;

	// character sequencer: start, 8 data lsb first, parity, stops
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = bit_end ? '0 : cnt_r + 1'b1;
		bit_nxt = bit_r;
		sh_nxt = sh_r;
		par_nxt = par_r;
		stop2_nxt = stop2_r;
		txd_nxt = txd_r;
		case (st_r)
			T_IDLE: begin
				cnt_nxt = '0;
				txd_nxt = 1'b1;
				if (txp.start) begin
					st_nxt = T_START;
					sh_nxt = txp.data;
					par_nxt = txp.par_odd;
					stop2_nxt = txp.two_stop;
					txd_nxt = 1'b0;
				end
			end
			T_START, T_DATA: if (bit_end) begin
				if (st_r == T_DATA && bit_r == 3'h7)
					st_nxt = txp.par_en ? T_PAR : T_STOP;
				else
					st_nxt = T_DATA;
				if (st_r == T_DATA)
					bit_nxt = bit_r + 1'b1;
				if (st_nxt == T_DATA) begin
					txd_nxt = sh_r[0];
					par_nxt = par_r ^ sh_r[0];
					sh_nxt = {1'b0, sh_r[7:1]};
				end else
					txd_nxt = (st_nxt == T_PAR) ? par_r : 1'b1;
			end
			T_PAR: if (bit_end) begin
				st_nxt = T_STOP;
				txd_nxt = 1'b1;
			end
			T_STOP: if (bit_end) begin
				if (stop2_r)
					stop2_nxt = 1'b0;
				else
					st_nxt = T_IDLE;
			end
			default: st_nxt = T_IDLE;
		endcase
	end

	// sequencer registers, line idles high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= T_IDLE;
			cnt_r <= '0;
			bit_r <= '0;
			sh_r <= '0;
			par_r <= 1'b0;
			stop2_r <= 1'b0;
			txd_r <= 1'b1;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			bit_r <= bit_nxt;
			sh_r <= sh_nxt;
			par_r <= par_nxt;
			stop2_r <= stop2_nxt;
			txd_r <= txd_nxt;
		end
	end
endmodule // rsl_tx

//--- include/rsl_pkg.sv
package rsl_pkg;
	// clock and timing
	localparam int CLK_HZ = 20_000_000;
	localparam int MS_PER_S = 1000;
	localparam int DS_PER_S = 10;
	localparam int MS_CYC = CLK_HZ / MS_PER_S;
	localparam int DS_CYC = CLK_HZ / DS_PER_S;
	localparam int REPLY_MAX_MS = 200;
	localparam int TIMEOUT_MAX_DS = 600;
	// line rates in bits per second
	localparam int RATE_19200 = 19200;
	localparam int RATE_38400 = 38400;
	localparam int RATE_57600 = 57600;
	localparam int RATE_115200 = 115200;
	localparam int DIV_W = 11;
	// line rate codes
	localparam logic [2:0] LR_19200 = 3'h4;
	localparam logic [2:0] LR_38400 = 3'h5;
	localparam logic [2:0] LR_57600 = 3'h6;
	localparam logic [2:0] LR_115200 = 3'h7;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DELAY = 8'h04;
	localparam logic [7:0] OFS_TMO = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0C;
	localparam logic [7:0] OFS_MASK = 8'h10;
	localparam logic [7:0] OFS_TXD = 8'h14;
	localparam logic [7:0] OFS_RXD = 8'h18;
	// control fields
	localparam int CTRL_RATE_LSB = 0;
	localparam int CTRL_FMT_LSB = 4;
	localparam logic [2:0] RATE_RST = 3'h4;
	localparam logic [2:0] FMT_RST = 3'h0;
	localparam logic [7:0] DELAY_RST = 8'h00;
	localparam logic [9:0] TMO_RST = 10'h000;
	// status bits
	localparam int ST_RX = 0;
	localparam int ST_RXERR = 1;
	localparam int ST_TXDONE = 2;
	localparam int ST_TMO = 3;
	localparam int ST_PEND = 4;
	localparam int NEV = 4;
	// divisor for a line rate code, rounded to nearest cycle
	function automatic logic [DIV_W-1:0] rate_div(input logic [2:0] sel);
		int r;
		case (sel)
			LR_38400: r = RATE_38400;
			LR_57600: r = RATE_57600;
			LR_115200: r = RATE_115200;
			default: r = RATE_19200;
		endcase
		return DIV_W'((CLK_HZ + r / 2) / r);
	endfunction
endpackage

//--- include/rsl_tx_if.sv
`timescale 1ns/1ns
interface rsl_tx_if;
	logic start;
	logic [7:0] data;
	logic [rsl_pkg::DIV_W-1:0] div;
	logic par_en;
	logic par_odd;
	logic two_stop;
	logic busy;
	modport ctl(output start, data, div, par_en, par_odd, two_stop,
		input busy);
	modport tx(input start, data, div, par_en, par_odd, two_stop,
		output busy);
endinterface

//--- tb/rsl_host.sv
`timescale 1ns/1ns
module rsl_host (
	// clock
	input wire logic pclk,
	// serial lines
	output logic rxd,
	input wire logic txd
);
	int div = 1042;
	bit pe = 1'b0;
	bit po = 1'b0;
	bit ts = 1'b0;
	// idle line is high
	initial rxd = 1'b1;
	// one character to the device, lsb first
	task automatic send(input logic [7:0] b, input bit bad);
		bit q[$];
		q.push_back(1'b0);
		for (int i = 0; i < 8; i++) q.push_back(b[i]);
		if (pe) q.push_back(^b ^ po ^ bad);
		q.push_back(1'b1);
		if (ts) q.push_back(1'b1);
		foreach (q[i]) begin
			rxd <= q[i];
			repeat (div) @(posedge pclk);
		end
	endtask
	// one character from the device, sampled mid-bit
	task automatic recv(output logic [7:0] d, output logic p,
		output logic s, output int w);
		w = 0;
		p = 1'b0;
		while (txd === 1'b1 && w < 9000) begin
			@(posedge pclk);
			w++;
		end
		repeat (div / 2) @(posedge pclk);
		for (int i = 0; i < 8; i++) begin
			repeat (div) @(posedge pclk);
			d[i] = txd;
		end
		if (pe) begin
			repeat (div) @(posedge pclk);
			p = txd;
		end
		repeat (div) @(posedge pclk);
		s = txd;
		if (ts) begin
			repeat (div) @(posedge pclk);
			s = s & txd;
		end
	endtask
endmodule // rsl_host

//--- tb/rsl_link_monitor.sv
`timescale 1ns/1ns
module rsl_link_monitor (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// line and interrupt
	input wire logic rxd,
	input wire logic txd,
	input wire logic irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// access phase of a transfer
	wire acc = psel && penable;
	zero_wait_a: assert property (acc |-> pready)
		else $error("access without ready");
	bad_addr_a: assert property (acc && paddr > 8'h18 |-> pslverr)
		else $error("unmapped access without error");
	good_addr_a: assert property
		(acc && paddr <= 8'h18 && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("mapped access with error");
	err_read_a: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	idle_line_a: assert property ($rose(presetn) |-> txd)
		else $error("line not idle after reset");
	quiet_irq_a: assert property ($rose(presetn) |-> !irq)
		else $error("interrupt after reset");
	start_bit_a: assert property ($fell(txd) |=> !txd [*8])
		else $error("start bit too short");
	mask_off_a: assert property
		(acc && pwrite && paddr == 8'h10 && pwdata[3:0] == 4'h0 |=> !irq)
		else $error("interrupt with all masked");
endmodule // rsl_link_monitor

bind rsl_link rsl_link_monitor mon (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .rxd(rxd), .txd(txd), .irq(irq));

//--- tb/rsl_link_tb_top.sv
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
	$display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module rsl_link_tb_top;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic rxd, txd, irq, e, p, s, uw;
	logic [7:0] paddr, b, d, ua;
	logic [31:0] pwdata, prdata, rd;
	int n_errors = 0;
	int checks = 0;
	int seed = 32'hc8d1a0df;
	int w;
	logic [7:0] txq[$];
	// clock
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	rsl_link #(.MS_CYCLES(20), .DS_CYCLES(200)) uut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd),
		.irq(irq));
	rsl_host host (.pclk(pclk), .rxd(rxd), .txd(txd));
	task automatic complete_run();
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] v);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			n_errors++;
			complete_run();
		end
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic fmt_set(input int f, input int c);
		int r;
		r = c == 7 ? 115200 : c == 6 ? 57600 : c == 5 ? 38400 : 19200;
		apb(1'b1, 8'h00, 32'(f * 16 + c));
		host.div = (20000000 + r / 2) / r;
		host.pe = f % 3 != 0;
		host.po = f % 3 == 2;
		host.ts = f >= 3;
	endtask
	task automatic get_tx();
		logic [7:0] x;
		host.recv(d, p, s, w);
		if (w >= 9000) begin
			n_errors++;
			complete_run();
		end
		x = txq.pop_front();
		`CHK({d, s}, {x, 1'b1})
		`CHK(p, host.pe & (^x ^ host.po))
		// let the last stop bit finish before the next request
		repeat (host.div) @(posedge pclk);
	endtask
	// main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata, presetn} = '0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// unmapped access of random direction, address and data
		ua = 8'($random(seed)) | 8'h20;
		uw = 1'($random(seed));
		apb(uw, ua, $random(seed));
		`CHK(e, 1'b1)
		if (!uw)
			`CHK(rd, 32'h0)
		apb(1'b0, 8'h00, 0);
		`CHK(rd, 32'h4)
		for (int f = 0; f < 6; f++) begin
			fmt_set(f, 5 + f % 3);
			b = $random(seed);
			txq.push_back(b);
			apb(1'b1, 8'h14, b);
			get_tx();
			b = $random(seed);
			host.send(b, 1'b0);
			apb(1'b0, 8'h0C, 0);
			`CHK(rd[3:0], 4'h5)
			apb(1'b0, 8'h18, 0);
			`CHK(rd[7:0], b)
			apb(1'b1, 8'h0C, 32'hF);
			$display("format %0d done", f);
		end
		fmt_set(1, 7);
		apb(1'b1, 8'h10, 32'h2);
		host.send(8'h5A, 1'b1);
		`CHK(irq, 1'b1)
		apb(1'b0, 8'h0C, 0);
		`CHK(rd[1:0], 2'h2)
		apb(1'b1, 8'h10, 0);
		`CHK(irq, 1'b0)
		apb(1'b1, 8'h0C, 32'hF);
		$display("parity done");
		apb(1'b1, 8'h04, 200);
		apb(1'b1, 8'h04, 201);
		apb(1'b0, 8'h04, 0);
		`CHK(rd, 32'd200)
		host.send(8'h11, 1'b0);
		txq.push_back(8'h3C);
		apb(1'b1, 8'h14, 8'h3C);
		apb(1'b0, 8'h0C, 0);
		`CHK(rd[4], 1'b1)
		get_tx();
		`CHK(w + host.div > 3900 && w < 4010, 1'b1)
		apb(1'b1, 8'h04, 0);
		txq.push_back(8'hC3);
		apb(1'b1, 8'h14, 8'hC3);
		get_tx();
		`CHK(w < 8, 1'b1)
		$display("delay done");
		apb(1'b1, 8'h08, 601);
		apb(1'b1, 8'h08, 3);
		apb(1'b0, 8'h08, 0);
		`CHK(rd, 32'd3)
		host.send(8'h22, 1'b0);
		apb(1'b1, 8'h0C, 32'hF);
		repeat (400) @(posedge pclk);
		apb(1'b0, 8'h0C, 0);
		`CHK(rd[3], 1'b0)
		repeat (150) @(posedge pclk);
		apb(1'b0, 8'h0C, 0);
		`CHK(rd[3], 1'b1)
		apb(1'b1, 8'h08, 0);
		apb(1'b1, 8'h0C, 32'hF);
		repeat (800) @(posedge pclk);
		apb(1'b0, 8'h0C, 0);
		`CHK(rd[3], 1'b0)
		$display("timeout done");
		// mid-run reset with an interrupt standing
		apb(1'b1, 8'h10, 32'hF);
		host.send(8'h33, 1'b1);
		`CHK(irq, 1'b1)
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		`CHK(irq, 1'b0)
		apb(1'b0, 8'h0C, 0);
		`CHK(rd, 32'h0)
		apb(1'b0, 8'h10, 0);
		`CHK(rd, 32'h0)
		apb(1'b0, 8'h00, 0);
		`CHK(rd, 32'h4)
		// one character at the lowest line rate code
		fmt_set(0, 4);
		b = $random(seed);
		txq.push_back(b);
		apb(1'b1, 8'h14, b);
		get_tx();
		$display("reset done");
		complete_run();
	end
endmodule // rsl_link_tb_top
